//--- ris_regs.vh
// ris_regs.vh: widths, reset values and encodings for the rgb input sampler
// assumes it is included by bare name from the sampler design files
`ifndef RIS_REGS_VH
`define RIS_REGS_VH

`define RIS_PIX_W 24
`define RIS_CNT_W 11
`define RIS_CNT_ZERO 11'h000
`define RIS_CNT_ONE 11'h001
`define RIS_PIX_ZERO 24'h00_0000
`define RIS_PORT_A 1'b0
`define RIS_PORT_B 1'b1
`define RIS_ARM_CLEAR 3'h0

`endif

//--- ris_sync_edge.v
// ris_sync_edge.v: two-stage synchroniser with edge detection for one outside level
// assumes the input is asynchronous to CLK; edge pulses are one CLK cycle wide
`timescale 1ns/1ns
`default_nettype none
`include "ris_regs.vh"
module ris_sync_edge (
   input wire CLK,
   input wire RESETN,
   input wire async_in,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta_ff;
   reg sync_ff;
   reg last_ff;
   // edges stay masked until last_ff holds a real pin sample, so an idle-high pin gives no edge after reset
   reg [2:0] armed_ff;

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
         armed_ff <= `RIS_ARM_CLEAR;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
         armed_ff <= {armed_ff[1:0], 1'b1};
      end
   end

   assign level = sync_ff;
   assign rise = armed_ff[2] & sync_ff & ~last_ff;
   assign fall = armed_ff[2] & ~sync_ff & last_ff;
endmodule // ris_sync_edge
`default_nettype wire

//--- ris_rgb_input_sampler.v
// ris_rgb_input_sampler.v: rgb pixel sampler with sample window, clamp and gain-correction pulses
// assumes the sample clock runs well below CLK/2 and that port data is stable around each sample edge
//
// Notes on behaviour
// R1 - one adc samples on rising sample clock edge; two adcs on both edges
// R2 - pixels accepted only inside window set by four offsets and lengths
// R3 - offset counters start at second edge of frame and line sync
// R4 - frame and line sync polarity each set by own polarity input
// R5 - vertical offset counts lines, horizontal offset counts pixels
// R6 - configuring party sets height in lines, even width in pixels
// R7 - source drives sample clock at half dot clock in dual mode
// R8 - single adc mode takes one pixel from port a each clock
// R9 - dual adc mode takes a pixel each edge, alternating ports a and b
// R10 - a flag selects whether the first pixel of a line is from a or b
// R11 - clamp counters advance at half the dot clock rate
// R12 - clamp asserts at on-count, deasserts at off-count, from line sync second edge
// R13 - clamp active level follows a polarity input
// R14 - gain correction is line sync delayed in half dot clock units
// R15 - first sync edge delayed by on-delay, second by off-delay
// R16 - gain correction active level follows a polarity input
// R17 - pixels outside window dropped; counters restart every line and frame
`timescale 1ns/1ns
`default_nettype none
`include "ris_regs.vh"
module ris_rgb_input_sampler (
   input wire CLK,
   input wire RESETN,
   input wire ADC_SAMPLE_CLOCK,
   input wire INPUT_FRAME_SYNC,
   input wire INPUT_LINE_SYNC,
   input wire [23:0] PORT_A,
   input wire [23:0] PORT_B,
   input wire DUAL_ADC,
   input wire FRAME_SYNC_POLARITY,
   input wire LINE_SYNC_POLARITY,
   input wire START_PORT_B,
   input wire [10:0] V_OFFSET,
   input wire [10:0] H_OFFSET,
   input wire [10:0] V_LENGTH,
   input wire [10:0] H_LENGTH,
   input wire [10:0] CLAMP_ON,
   input wire [10:0] CLAMP_OFF,
   input wire CLAMP_POLARITY,
   input wire [10:0] GAINC_ON_DELAY,
   input wire [10:0] GAINC_OFF_DELAY,
   input wire GAINC_POLARITY,
   output reg [23:0] PIXEL_DATA,
   output reg PIXEL_VALID,
   output reg PIXEL_FROM_B,
   output reg CLAMP,
   output reg GAINC
);
   wire sclk_rise;
   wire sclk_fall;
   wire fs_level;
   wire fs_rise;
   wire fs_fall;
   wire ls_level;
   wire ls_rise;
   wire ls_fall;
   reg [23:0] pa_meta_ff;
   reg [23:0] pa_sync_ff;
   reg [23:0] pb_meta_ff;
   reg [23:0] pb_sync_ff;

   ris_sync_edge u_sclk (
      .CLK(CLK), .RESETN(RESETN), .async_in(ADC_SAMPLE_CLOCK),
      .level(), .rise(sclk_rise), .fall(sclk_fall)
   );
   ris_sync_edge u_fs (
      .CLK(CLK), .RESETN(RESETN), .async_in(INPUT_FRAME_SYNC),
      .level(fs_level), .rise(fs_rise), .fall(fs_fall)
   );
   ris_sync_edge u_ls (
      .CLK(CLK), .RESETN(RESETN), .async_in(INPUT_LINE_SYNC),
      .level(ls_level), .rise(ls_rise), .fall(ls_fall)
   );

   // pixel ports are sampled through two stages, same latency as the clock edge detector
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         pa_meta_ff <= `RIS_PIX_ZERO;
         pa_sync_ff <= `RIS_PIX_ZERO;
         pb_meta_ff <= `RIS_PIX_ZERO;
         pb_sync_ff <= `RIS_PIX_ZERO;
      end else begin
         pa_meta_ff <= PORT_A;
         pa_sync_ff <= pa_meta_ff;
         pb_meta_ff <= PORT_B;
         pb_sync_ff <= pb_meta_ff;
      end
   end

   // polarity: active-high sync has its leading edge rising, so its second edge falls
   wire fs_first = FRAME_SYNC_POLARITY ? fs_rise : fs_fall; // R4
   wire fs_second = FRAME_SYNC_POLARITY ? fs_fall : fs_rise; // R4
   wire ls_first = LINE_SYNC_POLARITY ? ls_rise : ls_fall; // R4
   wire ls_second = LINE_SYNC_POLARITY ? ls_fall : ls_rise; // R4
   wire fs_active = FRAME_SYNC_POLARITY ? fs_level : ~fs_level;

   wire samp_edge = DUAL_ADC ? (sclk_rise | sclk_fall) : sclk_rise; // R1 R8 R9
   // half dot clock: one tick per sample clock rise in dual mode, every other dot in single mode
   reg half_ff;
   wire half_tick = DUAL_ADC ? sclk_rise : (sclk_rise & half_ff); // R11 R14

   reg [10:0] line_cnt_ff;
   reg [10:0] pix_cnt_ff;
   reg line_run_ff;
   reg pix_run_ff;
   reg port_sel_ff;
   reg [10:0] clamp_cnt_ff;
   reg clamp_run_ff;
   reg clamp_on_ff;
   reg [10:0] gon_cnt_ff;
   reg [10:0] goff_cnt_ff;
   reg gon_run_ff;
   reg goff_run_ff;
   reg gainc_act_ff;

   function cnt_hit;
      input [10:0] cnt;
      input [10:0] lim;
      begin
         cnt_hit = (cnt == lim);
      end
   endfunction

   // one spare bit, so a window reaching the counter top does not wrap into an empty window
   wire [11:0] v_end = {1'b0, V_OFFSET} + {1'b0, V_LENGTH};
   wire [11:0] h_end = {1'b0, H_OFFSET} + {1'b0, H_LENGTH};
   wire v_in = line_run_ff & (line_cnt_ff >= V_OFFSET) & ({1'b0, line_cnt_ff} < v_end); // R2 R5
   wire h_in = pix_run_ff & (pix_cnt_ff >= H_OFFSET) & ({1'b0, pix_cnt_ff} < h_end); // R2 R5

   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         line_cnt_ff <= `RIS_CNT_ZERO;
         pix_cnt_ff <= `RIS_CNT_ZERO;
         line_run_ff <= 1'b0;
         pix_run_ff <= 1'b0;
         port_sel_ff <= `RIS_PORT_A;
         half_ff <= 1'b0;
         PIXEL_DATA <= `RIS_PIX_ZERO;
         PIXEL_VALID <= 1'b0;
         PIXEL_FROM_B <= 1'b0;
      end else begin
         PIXEL_VALID <= 1'b0;
         if (fs_second) begin
            line_cnt_ff <= `RIS_CNT_ZERO; // R3 R17
            line_run_ff <= 1'b1;
         end else if (ls_second && line_run_ff && !fs_active) begin
            line_cnt_ff <= line_cnt_ff + `RIS_CNT_ONE; // R5
         end
         if (ls_first) begin
            pix_run_ff <= 1'b0; // R17
            port_sel_ff <= START_PORT_B ? `RIS_PORT_B : `RIS_PORT_A; // R10
            half_ff <= 1'b0;
         end else if (ls_second) begin
            pix_cnt_ff <= `RIS_CNT_ZERO; // R3 R17
            pix_run_ff <= 1'b1;
         end else if (samp_edge) begin
            half_ff <= ~half_ff;
            if (pix_run_ff) begin
               if (v_in && h_in) begin // R2 R17
                  PIXEL_VALID <= 1'b1;
                  PIXEL_DATA <= (DUAL_ADC && port_sel_ff) ? pb_sync_ff : pa_sync_ff; // R8 R9
                  PIXEL_FROM_B <= DUAL_ADC & port_sel_ff;
               end
               pix_cnt_ff <= pix_cnt_ff + `RIS_CNT_ONE; // R5
               if (DUAL_ADC) begin
                  port_sel_ff <= ~port_sel_ff; // R9
               end
            end
         end
      end
   end

   // clamp: count half-dot ticks from the second line sync edge
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         clamp_cnt_ff <= `RIS_CNT_ZERO;
         clamp_run_ff <= 1'b0;
         clamp_on_ff <= 1'b0;
         CLAMP <= 1'b0;
      end else begin
         if (ls_second) begin
            clamp_cnt_ff <= `RIS_CNT_ZERO; // R12
            clamp_run_ff <= 1'b1;
            clamp_on_ff <= cnt_hit(`RIS_CNT_ZERO, CLAMP_ON) & ~cnt_hit(`RIS_CNT_ZERO, CLAMP_OFF);
         end else if (clamp_run_ff && half_tick) begin
            clamp_cnt_ff <= clamp_cnt_ff + `RIS_CNT_ONE; // R11
            if (cnt_hit(clamp_cnt_ff + `RIS_CNT_ONE, CLAMP_OFF)) begin
               clamp_on_ff <= 1'b0; // R12
               clamp_run_ff <= 1'b0;
            end else if (cnt_hit(clamp_cnt_ff + `RIS_CNT_ONE, CLAMP_ON)) begin
               clamp_on_ff <= 1'b1; // R12
            end
         end
         CLAMP <= clamp_on_ff ^ ~CLAMP_POLARITY; // R13
      end
   end

   // gain correction: each line sync edge starts its own delay counter
   always @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         gon_cnt_ff <= `RIS_CNT_ZERO;
         goff_cnt_ff <= `RIS_CNT_ZERO;
         gon_run_ff <= 1'b0;
         goff_run_ff <= 1'b0;
         gainc_act_ff <= 1'b0;
         GAINC <= 1'b0;
      end else begin
         if (ls_first) begin
            gon_cnt_ff <= `RIS_CNT_ZERO; // R15
            gon_run_ff <= 1'b1;
         end else if (gon_run_ff && cnt_hit(gon_cnt_ff, GAINC_ON_DELAY)) begin
            gon_run_ff <= 1'b0;
            gainc_act_ff <= 1'b1; // R14 R15
         end else if (gon_run_ff && half_tick) begin
            gon_cnt_ff <= gon_cnt_ff + `RIS_CNT_ONE; // R14
         end
         if (ls_second) begin
            goff_cnt_ff <= `RIS_CNT_ZERO; // R15
            goff_run_ff <= 1'b1;
         end else if (goff_run_ff && cnt_hit(goff_cnt_ff, GAINC_OFF_DELAY)) begin
            goff_run_ff <= 1'b0;
            if (!(gon_run_ff && cnt_hit(gon_cnt_ff, GAINC_ON_DELAY))) begin
               gainc_act_ff <= 1'b0; // R15
            end
         end else if (goff_run_ff && half_tick) begin
            goff_cnt_ff <= goff_cnt_ff + `RIS_CNT_ONE; // R14
         end
         GAINC <= gainc_act_ff ^ ~GAINC_POLARITY; // R16
      end
   end

endmodule // ris_rgb_input_sampler
`default_nettype wire

//--- ris_rgb_input_sampler_assertions.sv
// ris_rgb_input_sampler_assertions.sv: port timing checks for the rgb input sampler
// assumes sample clock period of 16 CLK and mode inputs moved only while no pixel is due
`timescale 1ns/1ns
`default_nettype none
module ris_rgb_input_sampler_assertions (
   input wire CLK,
   input wire RESETN,
   input wire ADC_SAMPLE_CLOCK,
   input wire INPUT_LINE_SYNC,
   input wire LINE_SYNC_POLARITY,
   input wire DUAL_ADC,
   input wire CLAMP_POLARITY,
   input wire GAINC_POLARITY,
   input wire [23:0] PIXEL_DATA,
   input wire PIXEL_VALID,
   input wire PIXEL_FROM_B,
   input wire CLAMP,
   input wire GAINC
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence s_clk_still;
      $stable(ADC_SAMPLE_CLOCK)[*6];
   endsequence
   sequence s_sync_held;
      (INPUT_LINE_SYNC == LINE_SYNC_POLARITY)[*8];
   endsequence
   a_valid_one_cycle: assert property (PIXEL_VALID |=> !PIXEL_VALID) else $error("valid too long");
   a_single_port_a: assert property (PIXEL_VALID && !DUAL_ADC |-> !PIXEL_FROM_B) else $error("port b used");
   // a falling sample edge leaves the clock low, so a valid from it would see low here
   a_single_rise_only: assert property (PIXEL_VALID && !DUAL_ADC |-> $past(ADC_SAMPLE_CLOCK, 2)) else $error("fall");
   a_idle_no_pixel: assert property (s_clk_still |-> !PIXEL_VALID) else $error("pixel without edge");
   a_sync_refuses: assert property (s_sync_held |-> !PIXEL_VALID) else $error("pixel during sync");
   a_data_with_valid: assert property ($changed(PIXEL_DATA) |-> PIXEL_VALID) else $error("data moved");
   a_side_with_valid: assert property ($changed(PIXEL_FROM_B) |-> PIXEL_VALID) else $error("side moved");
   a_clamp_pol: assert property ($changed(CLAMP_POLARITY) |-> ##[1:3] $changed(CLAMP)) else $error("clamp pol");
   a_gainc_pol: assert property ($changed(GAINC_POLARITY) |-> ##[1:3] $changed(GAINC)) else $error("gainc pol");
endmodule // ris_rgb_input_sampler_assertions
bind ris_rgb_input_sampler ris_rgb_input_sampler_assertions u_chk (.CLK, .RESETN, .ADC_SAMPLE_CLOCK,
   .INPUT_LINE_SYNC, .LINE_SYNC_POLARITY, .DUAL_ADC, .CLAMP_POLARITY, .GAINC_POLARITY, .PIXEL_DATA,
   .PIXEL_VALID, .PIXEL_FROM_B, .CLAMP, .GAINC);
`default_nettype wire

//--- ris_adc_model.sv
// ris_adc_model.sv: video source with free sample clock, syncs and a ramp on both ports
// assumes the bench calls frame and line one at a time
`timescale 1ns/1ns
`default_nettype none
module ris_adc_model (
   output logic sclk,
   output wire fsync,
   output wire lsync,
   output logic [23:0] pa,
   output logic [23:0] pb,
   input wire logic fpol,
   input wire logic lpol
);
   logic fact = 0;
   logic lact = 0;
   int idx = 0;
   assign fsync = ~(fact ^ fpol);
   assign lsync = ~(lact ^ lpol);
   initial begin
      pa = 24'h00_0000;
      pb = 24'h00_0000;
      sclk = 0;
      forever #80 sclk = ~sclk;
   end
   // data moves half way between edges so it is steady around every sample edge
   always @(sclk) begin
      #40;
      idx++;
      pa = {8'hA0, idx[15:0]};
      pb = {8'hB0, idx[15:0]};
   end
   task frame();
      @(negedge sclk);
      #30 fact = 1;
      repeat (2) @(negedge sclk);
      #30 fact = 0;
   endtask
   // idx restarts so the first edge after the sync ends carries ramp value 0
   task line(input int n);
      @(negedge sclk);
      #30 lact = 1;
      repeat (2) @(negedge sclk);
      #30 lact = 0;
      idx = -1;
      repeat (n) @(sclk);
   endtask
endmodule // ris_adc_model
`default_nettype wire

//--- ris_rgb_input_sampler_tb.sv
// ris_rgb_input_sampler_tb.sv: self-checking bench for the rgb input sampler
// assumes the model and checker files are compiled first
`timescale 1ns/1ns
`default_nettype none
module ris_rgb_input_sampler_tb;
   logic clk, resetn, dual, spb, lpol, fpol, cpol, gpol, meas;
   logic [10:0] hoff, hlen, goff, voff, vlen, con, coff, gon;
   wire sclk, fsync, lsync, valid, from_b, clamp, gainc;
   wire [23:0] pa, pb, data;
   logic [24:0] q[$];
   int fail_count, n_checks, ncl, nga;
   ris_adc_model u_src (.sclk, .fsync, .lsync, .pa, .pb, .fpol, .lpol);
   ris_rgb_input_sampler dut (.CLK(clk), .RESETN(resetn), .ADC_SAMPLE_CLOCK(sclk), .INPUT_FRAME_SYNC(fsync),
      .INPUT_LINE_SYNC(lsync), .PORT_A(pa), .PORT_B(pb), .DUAL_ADC(dual), .FRAME_SYNC_POLARITY(fpol),
      .LINE_SYNC_POLARITY(lpol), .START_PORT_B(spb), .V_OFFSET(voff), .H_OFFSET(hoff), .V_LENGTH(vlen),
      .H_LENGTH(hlen), .CLAMP_ON(con), .CLAMP_OFF(coff), .CLAMP_POLARITY(cpol),
      .GAINC_ON_DELAY(gon), .GAINC_OFF_DELAY(goff), .GAINC_POLARITY(gpol), .PIXEL_DATA(data),
      .PIXEL_VALID(valid), .PIXEL_FROM_B(from_b), .CLAMP(clamp), .GAINC(gainc));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (valid === 1'b1) q.push_back({from_b, data});
      if (meas) ncl += (clamp === cpol);
      if (meas) nga += (gainc === gpol);
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("FAIL %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // pixel k of a line carries ramp value of its sample edge; single mode uses rising edges only
   task expect_px(input int k0, input int n);
      logic [24:0] e;
      int k;
      chk(q.size(), n);
      for (int i = 0; i < n && q.size() > 0; i++) begin
         k = dual ? k0 + i : 2 * (k0 + i);
         e[24] = dual & (k[0] ^ spb);
         e[23:0] = {e[24] ? 8'hB0 : 8'hA0, k[15:0]};
         chk(q.pop_front(), e);
      end
      q.delete();
   endtask
   task t_single;
      u_src.line(16);
      expect_px(0, 0);
      u_src.frame();
      u_src.line(16);
      expect_px(2, 4);
      u_src.line(16);
      expect_px(0, 0);
      u_src.frame();
      u_src.line(16);
      expect_px(2, 4);
   endtask
   task t_dual;
      for (int s = 0; s < 2; s++) begin
         @(negedge clk);
         dual = 1;
         hoff = 11'h001;
         spb = s[0];
         u_src.frame();
         u_src.line(16);
         expect_px(1, 4);
      end
   endtask
   task t_polarity;
      logic c, g;
      @(negedge clk);
      c = clamp;
      g = gainc;
      lpol = 0;
      fpol = 0;
      cpol = ~cpol;
      gpol = ~gpol;
      repeat (4) @(negedge clk);
      chk({clamp, gainc}, {~c, ~g});
      q.delete();
      u_src.frame();
      u_src.line(16);
      expect_px(1, 4);
   endtask
   task t_pulses;
      @(negedge clk);
      meas = 1;
      u_src.line(24);
      meas = 0;
      chk(ncl, 48);
      chk(nga, 64);
   endtask
   // single mode: half dot tick is every second sample clock rise, 32 CLK apart
   task t_pulses_single;
      @(negedge clk);
      dual = 0;
      con = 11'h001;
      coff = 11'h003;
      gon = 11'h002;
      goff = 11'h004;
      {ncl, nga} = 0;
      meas = 1;
      u_src.line(24);
      meas = 0;
      chk(ncl, 64);
      chk(nga, 96);
   endtask
   task t_window;
      @(negedge clk);
      voff = 11'h002;
      vlen = 11'h002;
      hoff = 11'h001;
      hlen = 11'h002;
      q.delete();
      u_src.frame();
      u_src.line(16);
      expect_px(0, 0);
      u_src.line(16);
      expect_px(1, 2);
      u_src.line(16);
      expect_px(1, 2);
      u_src.line(16);
      expect_px(0, 0);
   endtask
   task results;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      {resetn, dual, spb, meas, fail_count, n_checks, ncl, nga} = 0;
      {lpol, fpol, cpol, gpol} = 4'hF;
      hoff = 11'h002;
      hlen = 11'h004;
      goff = 11'h003;
      voff = 11'h001;
      vlen = 11'h001;
      con = 11'h002;
      coff = 11'h005;
      gon = 11'h001;
      repeat (4) @(negedge clk);
      resetn = 1;
      t_single;
      t_dual;
      t_polarity;
      t_pulses;
      t_pulses_single;
      t_window;
      results;
   end
   initial begin
      #100000;
      fail_count++;
      results;
   end
endmodule // ris_rgb_input_sampler_tb
`default_nettype wire
